// [shared/frame_port_pkg.sv]
// Constants shared by the 24-bit serial frame port and its checksum helper.
// Assumes the frame carries a 21-bit body followed by a 3-bit checksum.
package frame_port_pkg;

    // Frame geometry.
    localparam int FRAME_BITS = 24;
    localparam int CRC_BITS   = 3;
    localparam int BODY_BITS  = FRAME_BITS - CRC_BITS;
    localparam int COUNT_BITS = 5;

    // Bit counter limits.
    localparam logic [4:0] COUNT_ONE  = 5'h01;
    localparam logic [4:0] COUNT_FULL = 5'h18;
    localparam logic [4:0] COUNT_SAT  = 5'h1F;

    // Checksum: generator x^3+x+1, seed 101, effective start 100.
    localparam logic [2:0] CRC_SEED  = 3'h5;
    localparam logic [2:0] CRC_START = 3'h4;
    localparam logic [2:0] CRC_POLY  = 3'h3;
    localparam logic [2:0] CRC_RESID = 3'h0;

    // Received body layout: write flag, address, data.
    localparam int RX_WRITE_POS = 20;
    localparam int RX_ADDR_HI   = 19;
    localparam int RX_ADDR_LO   = 14;
    localparam int RX_DATA_HI   = 13;
    localparam int RX_DATA_LO   = 0;
    localparam int ADDR_BITS    = RX_ADDR_HI - RX_ADDR_LO + 1;
    localparam int DATA_BITS    = RX_DATA_HI - RX_DATA_LO + 1;

    // Transmitted body layout: last-frame error flag, then live status word.
    localparam int TX_ERR_POS    = 20;
    localparam int TX_STATUS_HI  = 19;
    localparam int STATUS_BITS   = TX_STATUS_HI + 1;

    // Link timing figures.
    localparam int MCLK_HZ            = 25000000;
    localparam int SCLK_MIN_PERIOD_NS = 100;
    localparam int SEQ_DELAY_NS       = 330;
    localparam int SEQ_DELAY_CYCLES   = (SEQ_DELAY_NS * (MCLK_HZ / 1000000) + 999) / 1000;

    // Counter widths and reset values.
    localparam int         ERRCNT_BITS = 8;
    localparam logic [7:0] ERRCNT_ZERO = 8'h00;
    localparam logic [7:0] ERRCNT_MAX  = 8'hFF;

endpackage

// [core/three_bit_checksum_calc.sv]
// Combinational three-bit checksum over a word, most significant bit first.
// Assumes the caller feeds a stable word; no clock inside.
`timescale 1ns/1ps

module three_bit_checksum_calc #(
    parameter int WIDTH = 24
) (
    // Word to cover
    input  wire logic [WIDTH-1:0] data,
    // Remainder after the last bit
    output logic      [2:0]       crc
);

    always_comb begin
        logic [2:0] acc;
        logic       fb;
        acc = frame_port_pkg::CRC_START;
        fb  = 1'b0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            fb  = acc[2] ^ data[i];
            acc = {acc[1:0], 1'b0} ^ (fb ? frame_port_pkg::CRC_POLY : 3'h0);
        end
        crc = acc;
    end

endmodule // three_bit_checksum_calc

// [core/spi_slave_three_bit_checksum_frame_port.sv]
// Serial slave port for 24-bit checksummed frames, device side.
// Assumes the master drives sclk and frame_select_n; mclk and sclk are unrelated.
`timescale 1ns/1ps

module spi_slave_three_bit_checksum_frame_port #(
    parameter int ADDR_W   = frame_port_pkg::ADDR_BITS,
    parameter int DATA_W   = frame_port_pkg::DATA_BITS,
    parameter int STATUS_W = frame_port_pkg::STATUS_BITS
) (
    // System clock and reset
    input  wire logic                mclk,
    input  wire logic                nrst,

    // Serial link from the master
    input  wire logic                sclk,
    input  wire logic                frame_select_n,
    input  wire logic                mosi,
    output logic                     miso_out,
    output logic                     miso_oe,

    // Live status to return in each read
    input  wire logic [STATUS_W-1:0] status_in,

    // Decoded command
    output logic                     cmd_valid,
    output logic                     cmd_write,
    output logic [ADDR_W-1:0]        cmd_addr,
    output logic [DATA_W-1:0]        cmd_data,

    // Frame error reporting
    output logic                     frame_error,
    output logic                     crc_error,
    output logic                     length_error,
    output logic                     last_frame_bad,
    output logic [7:0]               crc_error_count,
    output logic [7:0]               length_error_count,
    output logic                     link_busy
);

    typedef enum {
        ST_IDLE,
        ST_ACTIVE,
        ST_CHECK,
        ST_GAP
    } port_state_t;

    // Link-domain state, clocked by sclk.
    logic [frame_port_pkg::FRAME_BITS-1:0] rx_shift;
    logic [frame_port_pkg::FRAME_BITS-1:0] tx_shift;
    logic [frame_port_pkg::COUNT_BITS-1:0] bit_count;
    logic                                  fresh;
    logic                                  tx_started;

    // Core-domain state, clocked by mclk.
    logic [2:0]                            select_sync;
    logic                                  select_high;
    port_state_t                           state;
    port_state_t                           next_state;
    logic [frame_port_pkg::FRAME_BITS-1:0] tx_word;
    logic [frame_port_pkg::FRAME_BITS-1:0] rx_frame;
    logic [frame_port_pkg::COUNT_BITS-1:0] rx_count;
    logic [7:0]                            gap_count;

    // Checksum helpers.
    logic [2:0]                            rx_residue;
    logic [2:0]                            tx_crc;
    logic [frame_port_pkg::BODY_BITS-1:0]  tx_body;

    // Decode terms.
    logic                                  select_agree_high;
    logic                                  select_agree_low;
    logic                                  frame_end;
    logic                                  frame_start;
    logic                                  crc_ok;
    logic                                  length_ok;
    logic                                  frame_good;
    logic                                  gap_done;
    logic                                  link_bit;
    logic [frame_port_pkg::COUNT_BITS-1:0] next_bit_count;
    logic [7:0]                            next_crc_count;
    logic [7:0]                            next_len_count;

    // Link side: receive.

    // The fresh flag is set asynchronously while the frame is deselected, so a
    // new frame starts counting from its first rising edge even though sclk
    // may have stood still between frames.
    always_ff @(posedge sclk or posedge frame_select_n) begin
        if (frame_select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // The count is not cleared by frame select, so it stays frozen after the
    // frame for the core to read once the select has settled high.
    assign next_bit_count = fresh ? frame_port_pkg::COUNT_ONE :
                            (bit_count == frame_port_pkg::COUNT_SAT) ? bit_count :
                            bit_count + frame_port_pkg::COUNT_ONE;

    always_ff @(posedge sclk) begin
        if (!frame_select_n) begin
            rx_shift  <= {rx_shift[frame_port_pkg::FRAME_BITS-2:0], mosi};
            bit_count <= next_bit_count;
        end
    end

    // Link side: transmit.

    // Cleared while deselected and set by the first falling edge, so the most
    // significant bit stays on the pin for the whole first clock period.
    always_ff @(negedge sclk or posedge frame_select_n) begin
        if (frame_select_n) begin
            tx_started <= 1'b0;
        end else begin
            tx_started <= 1'b1;
        end
    end

    // The transmit word is changed by the core in ST_IDLE until it sees the select low, up to three mclk
    // cycles into the frame, so the first falling edge can read it while it is still being refreshed.
    always_ff @(negedge sclk) begin
        if (!frame_select_n) begin
            if (!tx_started) begin
                tx_shift <= {tx_word[frame_port_pkg::FRAME_BITS-2:0], 1'b0};
            end else begin
                tx_shift <= {tx_shift[frame_port_pkg::FRAME_BITS-2:0], 1'b0};
            end
        end
    end

    // Before the first falling edge the most significant bit is presented
    // straight from the prepared word; the pin path never sees mosi.
    assign link_bit = tx_started ? tx_shift[frame_port_pkg::FRAME_BITS-1] :
                      tx_word[frame_port_pkg::FRAME_BITS-1];

    // The pin must release within the access and disable times of the link,
    // which a flip-flop on mclk could not meet, so these two are gated
    // directly by the select.
    assign miso_out = link_bit & ~frame_select_n;
    assign miso_oe  = ~frame_select_n;

    // Core side: select synchroniser.

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            select_sync <= 3'h7;
        end else begin
            select_sync <= {select_sync[1:0], frame_select_n};
        end
    end

    assign select_agree_high = select_sync[1] & select_sync[2];
    assign select_agree_low  = ~select_sync[1] & ~select_sync[2];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            select_high <= 1'b1;
        end else if (select_agree_high) begin
            select_high <= 1'b1;
        end else if (select_agree_low) begin
            select_high <= 1'b0;
        end
    end

    assign frame_start = select_high & select_agree_low;
    assign frame_end   = ~select_high & select_agree_high;

    // Core side: frame check.

    three_bit_checksum_calc #(
        .WIDTH (frame_port_pkg::FRAME_BITS)
    ) rx_check (
        .data (rx_frame),
        .crc  (rx_residue)
    );

    assign crc_ok     = (rx_residue == frame_port_pkg::CRC_RESID);
    assign length_ok  = (rx_count == frame_port_pkg::COUNT_FULL);
    assign frame_good = crc_ok & length_ok;

    // Core side: response frame.

    assign tx_body = {last_frame_bad, status_in};

    three_bit_checksum_calc #(
        .WIDTH (frame_port_pkg::BODY_BITS)
    ) tx_gen (
        .data (tx_body),
        .crc  (tx_crc)
    );

    // Refreshed every idle cycle so each read returns the condition as it was
    // before the frame began, or before the previous one if it began in ST_GAP.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_word <= '0;
        end else if (state == ST_IDLE && select_high && !frame_start) begin
            tx_word <= {tx_body, tx_crc};
        end
    end

    // Core side: sequencing.

    assign gap_done = (gap_count >= 8'(frame_port_pkg::SEQ_DELAY_CYCLES - 1));

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (frame_start) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (frame_end) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                next_state = ST_GAP;
            end
            ST_GAP: begin
                if (gap_done || frame_start) begin
                    next_state = frame_start ? ST_ACTIVE : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gap_count <= 8'h00;
        end else if (state == ST_GAP) begin
            gap_count <= gap_count + 8'h01;
        end else begin
            gap_count <= 8'h00;
        end
    end

    // The receive register and count are frozen once the select is high, so
    // they are copied as a group without a per-bit synchroniser.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_frame <= '0;
            rx_count <= '0;
        end else if (state == ST_ACTIVE && frame_end) begin
            rx_frame <= rx_shift;
            rx_count <= bit_count;
        end
    end

    // Core side: decode and report.

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmd_valid <= 1'b0;
            cmd_write <= 1'b0;
            cmd_addr  <= '0;
            cmd_data  <= '0;
        end else begin
            cmd_valid <= (state == ST_CHECK) && frame_good;
            if (state == ST_CHECK && frame_good) begin
                cmd_write <= rx_frame[frame_port_pkg::RX_WRITE_POS + frame_port_pkg::CRC_BITS];
                cmd_addr  <= rx_frame[frame_port_pkg::RX_ADDR_HI + frame_port_pkg::CRC_BITS:
                                      frame_port_pkg::RX_ADDR_LO + frame_port_pkg::CRC_BITS];
                cmd_data  <= rx_frame[frame_port_pkg::RX_DATA_HI + frame_port_pkg::CRC_BITS:
                                      frame_port_pkg::RX_DATA_LO + frame_port_pkg::CRC_BITS];
            end
        end
    end

    assign next_crc_count = (crc_error_count == frame_port_pkg::ERRCNT_MAX) ?
                            crc_error_count : crc_error_count + 8'h01;
    assign next_len_count = (length_error_count == frame_port_pkg::ERRCNT_MAX) ?
                            length_error_count : length_error_count + 8'h01;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            frame_error  <= 1'b0;
            crc_error    <= 1'b0;
            length_error <= 1'b0;
        end else begin
            frame_error  <= (state == ST_CHECK) && !frame_good;
            crc_error    <= (state == ST_CHECK) && !crc_ok;
            length_error <= (state == ST_CHECK) && !length_ok;
        end
    end

    // The error flag is carried in the next reply begun after ST_GAP so the master can tell
    // that its previous access was dropped and repeat it.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            last_frame_bad <= 1'b0;
        end else if (state == ST_CHECK) begin
            last_frame_bad <= !frame_good;
        end
    end

    // Counters saturate rather than wrap so a long error burst is not hidden.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            crc_error_count    <= frame_port_pkg::ERRCNT_ZERO;
            length_error_count <= frame_port_pkg::ERRCNT_ZERO;
        end else if (state == ST_CHECK) begin
            if (!crc_ok) begin
                crc_error_count <= next_crc_count;
            end
            if (!length_ok) begin
                length_error_count <= next_len_count;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link_busy <= 1'b0;
        end else begin
            link_busy <= (next_state != ST_IDLE);
        end
    end

endmodule // spi_slave_three_bit_checksum_frame_port

// [bench/frame_port_chk.sv]
// Concurrent checks on the top-level ports of the serial frame port.
// Assumes the default port widths and mclk as the only sampling clock.
`timescale 1ns/1ps

module frame_port_chk (
    // Core clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Serial link
    input wire logic        frame_select_n,
    input wire logic        miso_out,
    input wire logic        miso_oe,
    // Decode results
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [5:0]  cmd_addr,
    input wire logic [13:0] cmd_data,
    input wire logic        frame_error,
    input wire logic        crc_error,
    input wire logic        length_error,
    input wire logic        last_frame_bad,
    input wire logic [7:0]  crc_error_count,
    input wire logic [7:0]  length_error_count,
    // Core activity
    input wire logic        link_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_result_ends;
        ##1 !cmd_valid && !frame_error;
    endsequence

    a_oe_tracks_select: assert property (miso_oe == !frame_select_n)
        else $error("output enable does not follow frame select");
    a_out_quiet_idle: assert property (frame_select_n |-> !miso_out)
        else $error("serial output active while deselected");
    a_result_one_cycle: assert property ((cmd_valid || frame_error) |-> s_result_ends)
        else $error("result pulse longer than one cycle");
    a_no_decode_mid_frame: assert property (!frame_select_n |-> !cmd_valid && !frame_error)
        else $error("frame decoded while select still low");
    a_bad_not_decoded: assert property (!(cmd_valid && frame_error))
        else $error("rejected frame also decoded");
    a_cmd_held: assert property (!cmd_valid |-> $stable({cmd_write, cmd_addr, cmd_data}))
        else $error("command fields moved without a good frame");
    a_error_cause: assert property (frame_error == (crc_error || length_error))
        else $error("frame error without matching cause");
    a_crc_count_step: assert property ($changed(crc_error_count) |->
        crc_error_count == $past(crc_error_count) + 8'h01 && (crc_error || $past(crc_error)))
        else $error("checksum error count moved wrongly");
    a_len_count_step: assert property ($changed(length_error_count) |->
        length_error_count == $past(length_error_count) + 8'h01 && (length_error || $past(length_error)))
        else $error("length error count moved wrongly");
    a_bad_flag_set: assert property (frame_error |-> ##[0:1] last_frame_bad)
        else $error("bad frame flag not set");
    a_bad_flag_clear: assert property (cmd_valid |-> ##[0:1] !last_frame_bad)
        else $error("bad frame flag not cleared");
    a_busy_on_result: assert property ((cmd_valid || frame_error) |-> link_busy)
        else $error("frame result while port reports idle");
endmodule // frame_port_chk

bind spi_slave_three_bit_checksum_frame_port frame_port_chk u_chk (
    .mclk(mclk), .nrst(nrst), .frame_select_n(frame_select_n), .miso_out(miso_out),
    .miso_oe(miso_oe), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .frame_error(frame_error), .crc_error(crc_error),
    .length_error(length_error), .last_frame_bad(last_frame_bad),
    .crc_error_count(crc_error_count), .length_error_count(length_error_count),
    .link_busy(link_busy));

// [bench/frame_master.sv]
// Behavioural bus master that makes sclk, frame select and serial data.
// Assumes the bench resolves the device output against its enable.
`timescale 1ns/1ps

module frame_master (
    // Serial lines
    output logic      sclk,
    output logic      frame_select_n,
    output logic      mosi,
    input  wire logic miso
);
    // Select rises just after time zero so the port's edge-set link flags
    // start from a known value instead of staying unknown until a frame ends.
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        #1;
        frame_select_n = 1'b1;
    end

    // Sends the low n bits of w and keeps the last 24 reply bits.
    // The clock stands still between frames, so no stray edges reach the port.
    task automatic xfer(input logic [24:0] w, input int n, output logic [23:0] got);
        got = 24'h000000;
        #7;
        frame_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = w[i];
            #40;
            sclk = 1'b1;
            got = {got[22:0], miso};
            #40;
            sclk = 1'b0;
        end
        #40;
        frame_select_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule // frame_master

// [bench/spi_slave_three_bit_checksum_frame_port_tb_top.sv]
// Self-checking bench for the serial frame port with a behavioural master.
// Assumes a 25 MHz core clock and an 80 ns link clock unrelated in phase.
`timescale 1ns/1ps

module spi_slave_three_bit_checksum_frame_port_tb_top;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [19:0] status_in = 20'h00000;
    logic        sclk, frame_select_n, mosi, miso_out, miso_oe, miso;
    logic        cmd_valid, cmd_write, frame_error, crc_error, length_error, last_frame_bad, link_busy;
    logic [5:0]  cmd_addr;
    logic [13:0] cmd_data;
    logic [7:0]  crc_error_count, length_error_count;
    logic [22:0] notes[$];
    logic [22:0] e;
    logic        bad = 1'b0;
    int          n_fail = 0;
    int          num_checks = 0;
    int          seed = 98;
    int          cycles = 0;

    always #20 mclk = ~mclk;
    // The pin has a pull-down, so a released line reads low.
    assign miso = miso_oe ? miso_out : 1'b0;

    frame_master u_master (.sclk(sclk), .frame_select_n(frame_select_n), .mosi(mosi), .miso(miso));

    spi_slave_three_bit_checksum_frame_port DUT (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .frame_select_n(frame_select_n), .mosi(mosi),
        .miso_out(miso_out), .miso_oe(miso_oe), .status_in(status_in), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .frame_error(frame_error),
        .crc_error(crc_error), .length_error(length_error), .last_frame_bad(last_frame_bad),
        .crc_error_count(crc_error_count), .length_error_count(length_error_count), .link_busy(link_busy));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic [2:0] sum3(input logic [20:0] w);
        logic [2:0] c;
        c = frame_port_pkg::CRC_START;
        for (int i = 20; i >= 0; i--)
            c = {c[1:0], 1'b0} ^ ((c[2] ^ w[i]) ? frame_port_pkg::CRC_POLY : 3'h0);
        return c;
    endfunction

    // Kind 0 good, 1 corrupted checksum, 2 one bit short, 3 one bit long.
    task automatic frame(input logic [1:0] kind);
        logic [20:0] body;
        logic [19:0] st;
        logic [23:0] w;
        logic [23:0] got;
        logic [24:0] wide;
        int          n;
        body = 21'($random(seed));
        st = 20'($random(seed));
        status_in <= st;
        repeat (4) @(posedge mclk);
        w = {body, sum3(body)};
        if (kind == 2'd1)
            w[0] = ~w[0];
        wide = (kind == 2'd3) ? {w, 1'b1} : (kind == 2'd2) ? {2'b00, w[23:1]} : {1'b0, w};
        n = (kind == 2'd3) ? 25 : (kind == 2'd2) ? 23 : 24;
        notes.push_back({(kind > 2'd1) ? 2'd2 : kind, body});
        check("idle busy", 32'h0, {31'h0, link_busy});
        // A random lead-in keeps the link clock out of step with mclk.
        #(1 + ($unsigned($random(seed)) % 30));
        u_master.xfer(wide, n, got);
        check("frame busy", 32'h1, {31'h0, link_busy});
        if (n == 24)
            check("reply", {8'h00, bad, st, sum3({bad, st})}, {8'h00, got});
        bad = (kind != 2'd0);
        repeat (12) @(posedge mclk);
    endtask

    // Takes the oldest note whenever the port reports a frame result.
    always @(negedge mclk) begin
        if (nrst && (cmd_valid === 1'b1 || frame_error === 1'b1)) begin
            if (notes.size() == 0) begin
                check("unexpected result", 32'h0, 32'h1);
            end else begin
                e = notes.pop_front();
                check("good frame", {31'h0, e[22:21] == 2'd0}, {31'h0, cmd_valid});
                if (e[22:21] == 2'd0)
                    check("command", {11'h0, e[20:0]}, {11'h0, cmd_write, cmd_addr, cmd_data});
                if (e[22:21] == 2'd1)
                    check("checksum error", 32'h1, {31'h0, crc_error});
                if (e[22:21] == 2'd2)
                    check("length error", 32'h1, {31'h0, length_error});
            end
        end
    end

    // A hang is cut short well past the expected run length.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 6; i++)
            frame(2'd0);
        frame(2'd1);
        frame(2'd1);
        frame(2'd0);
        check("checksum count", 32'h2, {24'h0, crc_error_count});
        frame(2'd2);
        frame(2'd3);
        frame(2'd0);
        check("length count", 32'h2, {24'h0, length_error_count});
        check("notes left", 32'h0, 32'(notes.size()));
        test_done();
    end
endmodule // spi_slave_three_bit_checksum_frame_port_tb_top
